// >>> hw/rsk_pkg.sv
package rsk_pkg;
  // seek command first byte: absolute seek and relative seek share the layout
  localparam logic [7:0] RSK_CMD_SEEK_OP     = 8'h0f;
  localparam int         RSK_CMD_REL_MSB_POS = 7;
  localparam int         RSK_CMD_DIR_POS     = 6;
  // status byte zero fields
  localparam int         RSK_ST0_EC_POS      = 4;
  localparam int         RSK_ST0_SE_POS      = 5;
  localparam logic [7:0] RSK_ST0_RESET       = 8'h00;
  localparam logic [7:0] RSK_PCN_RESET       = 8'h00;
  localparam logic [1:0] RSK_MODE_RESET      = 2'h0;
  // recalibrate step limit
  localparam logic [6:0] RSK_RECAL_MAX_STEPS = 7'h50;
  // format byte counts per mode
  localparam logic [5:0] RSK_IDX_LOW_CONV    = 6'h21;
  localparam logic [5:0] RSK_IDX_LOW_1M      = 6'h12;
  localparam logic [5:0] RSK_GAP2_CONV       = 6'h16;
  localparam logic [5:0] RSK_GAP2_1M         = 6'h29;
  localparam logic [5:0] RSK_VCO_CONV        = 6'h18;
  localparam logic [5:0] RSK_VCO_1M          = 6'h2b;
  localparam logic [5:0] RSK_WG_PRE_500K     = 6'h13;
  localparam logic [5:0] RSK_WG_PRE_1M       = 6'h26;
  localparam logic [5:0] RSK_CUSHION         = 6'h02;
  // step pulse width in clock cycles
  localparam logic [3:0] RSK_STEP_PULSE_CYC  = 4'h4;

  typedef struct packed {
    logic       gap;
    logic       wgate;
  } rsk_mode_t;

  typedef struct packed {
    logic [5:0] idx_low;
    logic [5:0] gap2_len;
    logic [5:0] vco_on;
    logic [5:0] wg_pre;
  } rsk_fmt_t;
endpackage

// >>> hw/rsk_stepper.sv
`timescale 1ns/1ns
`default_nettype none
module rsk_stepper
  import rsk_pkg::*;
#(
  parameter int INT_W = 16
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             ce_in,
  input  wire logic             go_in,
  input  wire logic [INT_W-1:0] interval_in,
  output logic                  tick_out,
  output logic                  pulse_out
);
  logic [INT_W-1:0] cnt_r;
  logic [3:0]       pw_r;
  logic             pw_zero;

  assign pw_zero   = (pw_r == 4'h0);
  assign pulse_out = !pw_zero;
  // tick marks each step slot; first tick waits one full interval
  assign tick_out  = go_in && (cnt_r == '0);

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cnt_r <= '0;
      pw_r  <= 4'h0;
    end else if (ce_in) begin
      if (!go_in) begin
        cnt_r <= interval_in;
      end else if (cnt_r == '0) begin
        cnt_r <= interval_in;
      end else begin
        cnt_r <= cnt_r - 1'b1;
      end
      if (tick_out) begin
        pw_r <= RSK_STEP_PULSE_CYC;
      end else if (!pw_zero) begin
        pw_r <= pw_r - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hw/rsk_gap_timer.sv
`timescale 1ns/1ns
`default_nettype none
module rsk_gap_timer
  import rsk_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       ce_in,
  input  wire logic       start_in,
  input  wire logic       byte_stb_in,
  output logic [5:0]      count_out
);
  logic [5:0] cnt_r;
  assign count_out = cnt_r;
  // counts byte strobes, saturates so a long gap cannot wrap back
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cnt_r <= 6'h00;
    end else if (ce_in) begin
      if (start_in) begin
        cnt_r <= 6'h00;
      end else if (byte_stb_in && cnt_r != 6'h3f) begin
        cnt_r <= cnt_r + 6'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hw/rsk_seek_gap.sv
`timescale 1ns/1ns
`default_nettype none
module rsk_seek_gap
  import rsk_pkg::*;
#(
  parameter int INT_W = 16
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             ce_in,
  input  wire logic             cmd_valid_in,
  input  wire logic [7:0]       cmd_op_in,
  input  wire logic [7:0]       cmd_cyl_in,
  input  wire logic             recal_in,
  input  wire logic             sense_int_in,
  input  wire logic             mode_wr_in,
  input  wire rsk_mode_t        mode_in,
  input  wire logic [INT_W-1:0] step_interval_setting_in,
  input  wire logic             track_zero_sense_in,
  input  wire logic             index_in,
  input  wire logic             byte_stb_in,
  input  wire logic             gap2_start_in,
  input  wire logic             write_op_in,
  output logic                  step_out,
  output logic                  dir_out,
  output logic                  busy_out,
  output logic                  int_out,
  output logic [7:0]            status_byte_zero_out,
  output logic [7:0]            present_cylinder_number_out,
  output logic                  pll_oscillator_enable_out,
  output logic                  write_gate_out,
  output logic                  index_osc_low_out,
  output rsk_fmt_t              fmt_out
);
  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    RSK_IDLE  = 4'b0001,
    RSK_SEEK  = 4'b0010,
    RSK_RSEEK = 4'b0100,
    RSK_RECAL = 4'b1000
  } rsk_state_t;

  rsk_state_t state_r;
  rsk_state_t state_nxt;
  logic [7:0] pcn_r;
  logic [7:0] ncn_r;
  logic [8:0] left_r;
  logic [6:0] recal_cnt_r;
  logic       dir_r;
  logic [7:0] st0_r;
  logic       int_r;
  logic       step_r;
  logic       busy_r;
  rsk_mode_t  mode_r;
  logic [1:0] tz_sync_r;
  logic [1:0] idx_sync_r;
  logic       tz_s;
  logic       idx_s;
  logic       idx_d_r;

  assign tz_s  = tz_sync_r[1];
  assign idx_s = idx_sync_r[1];

  // pin inputs pass two flops before use
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      tz_sync_r  <= 2'b00;
      idx_sync_r <= 2'b00;
      idx_d_r    <= 1'b0;
    end else if (ce_in) begin
      tz_sync_r  <= {tz_sync_r[0], track_zero_sense_in};
      idx_sync_r <= {idx_sync_r[0], index_in};
      idx_d_r    <= idx_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command decode
  logic is_seek;
  logic is_rel;
  logic rel_dir;
  logic go_seek;
  logic go_rseek;
  logic go_recal;

  // bits 7 and 6 carry relative and direction, so only the low six match
  assign is_seek  = cmd_op_in[RSK_CMD_DIR_POS-1:0] ==
                    RSK_CMD_SEEK_OP[RSK_CMD_DIR_POS-1:0];
  assign is_rel   = cmd_op_in[RSK_CMD_REL_MSB_POS];
  assign rel_dir  = cmd_op_in[RSK_CMD_DIR_POS];
  // a new command is taken only from idle, so seeks never overlap
  assign go_seek  = state_r == RSK_IDLE && cmd_valid_in && is_seek && !is_rel;
  assign go_rseek = state_r == RSK_IDLE && cmd_valid_in && is_seek && is_rel;
  assign go_recal = state_r == RSK_IDLE && recal_in && !cmd_valid_in;

  ////////////////////////////////////////////////////////////////////////
  // stepping
  logic moving;
  logic tick;
  logic step_pulse;
  logic abs_done;
  logic rel_done;
  logic recal_hit;
  logic recal_fail;
  logic out_past_zero;
  logic seek_end;

  // recal stops stepping at the limit, then waits out the pulse and the
  // synchroniser so a head reaching zero on the last step still counts
  assign moving   = (state_r != RSK_IDLE) && !seek_end &&
                    !(state_r == RSK_RECAL &&
                      recal_cnt_r == RSK_RECAL_MAX_STEPS);
  // absolute seek: eight-bit compare against wrapped cylinder
  assign abs_done = state_r == RSK_SEEK && pcn_r == ncn_r;
  assign rel_done = state_r == RSK_RSEEK && left_r == 9'h000;
  assign recal_hit  = state_r == RSK_RECAL && tz_s;
  assign recal_fail = state_r == RSK_RECAL && !tz_s &&
                      !step_pulse && !step_r &&
                      recal_cnt_r == RSK_RECAL_MAX_STEPS;
  assign seek_end = abs_done || rel_done || recal_hit || recal_fail;
  assign out_past_zero = tick && state_r == RSK_RSEEK && !dir_r && tz_s;

  rsk_stepper #(
    .INT_W (INT_W)
  ) u_stepper (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .ce_in       (ce_in),
    .go_in       (moving),
    .interval_in (step_interval_setting_in),
    .tick_out    (tick),
    .pulse_out   (step_pulse)
  );

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      RSK_IDLE: begin
        if (go_seek) begin
          state_nxt = RSK_SEEK;
        end else if (go_rseek) begin
          state_nxt = RSK_RSEEK;
        end else if (go_recal) begin
          state_nxt = RSK_RECAL;
        end
      end
      RSK_SEEK, RSK_RSEEK, RSK_RECAL: begin
        if (seek_end) begin
          state_nxt = RSK_IDLE;
        end
      end
      default: state_nxt = RSK_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_r <= RSK_IDLE;
      busy_r  <= 1'b0;
    end else if (ce_in) begin
      state_r <= state_nxt;
      busy_r  <= state_nxt != RSK_IDLE;
    end
  end

  // count of zero means 256 tracks, so nine bits hold the remainder
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      left_r      <= 9'h000;
      ncn_r       <= 8'h00;
      dir_r       <= 1'b0;
      recal_cnt_r <= 7'h00;
    end else if (ce_in) begin
      if (go_rseek) begin
        left_r <= (cmd_cyl_in == 8'h00) ? 9'h100 : {1'b0, cmd_cyl_in};
        dir_r  <= rel_dir;
      end else if (go_seek) begin
        ncn_r  <= cmd_cyl_in;
        dir_r  <= cmd_cyl_in > pcn_r;
      end else if (go_recal) begin
        dir_r       <= 1'b0;
        recal_cnt_r <= 7'h00;
      end else if (tick && !seek_end) begin
        if (state_r == RSK_RSEEK) begin
          left_r <= left_r - 9'h001;
        end
        if (state_r == RSK_RECAL) begin
          recal_cnt_r <= recal_cnt_r + 7'h01;
        end
      end
    end
  end

  // cylinder register wraps silently; no record of extended area
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pcn_r <= RSK_PCN_RESET;
    end else if (ce_in) begin
      if (recal_hit) begin
        pcn_r <= 8'h00;
      end else if (tick && !seek_end && state_r != RSK_RECAL) begin
        pcn_r <= dir_r ? pcn_r + 8'h01 : pcn_r - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status and interrupt
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      st0_r <= RSK_ST0_RESET;
      int_r <= 1'b0;
    end else if (ce_in) begin
      if (go_seek || go_rseek || go_recal) begin
        st0_r <= RSK_ST0_RESET;
      end else begin
        if (out_past_zero) begin
          st0_r[RSK_ST0_EC_POS] <= 1'b1;
        end
        if (recal_fail) begin
          st0_r[RSK_ST0_EC_POS] <= 1'b1;
          st0_r[7:6] <= 2'b01;
        end
        if (seek_end) begin
          st0_r[RSK_ST0_SE_POS] <= 1'b1;
        end
      end
      // a seek end in the sense cycle keeps the interrupt
      if (seek_end) begin
        int_r <= 1'b1;
      end else if (sense_int_in) begin
        int_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      step_r <= 1'b0;
    end else if (ce_in) begin
      step_r <= step_pulse;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // perpendicular mode and gap timing
  logic     perp_1m;
  logic     perp_500k;
  rsk_fmt_t fmt;
  logic [5:0] gap_cnt;
  logic [5:0] wg_point;
  logic       vco_on;
  logic       wg_on;
  logic       idx_low;
  logic       in_gap_r;
  logic [5:0] idx_cnt_r;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      mode_r <= RSK_MODE_RESET;
    end else if (ce_in && mode_wr_in) begin
      mode_r <= mode_in;
    end
  end

  // reserved code 10 falls through to conventional
  assign perp_1m   = mode_r.gap && mode_r.wgate;
  assign perp_500k = !mode_r.gap && mode_r.wgate;
  assign fmt.idx_low  = perp_1m ? RSK_IDX_LOW_1M : RSK_IDX_LOW_CONV;
  assign fmt.gap2_len = perp_1m ? RSK_GAP2_1M : RSK_GAP2_CONV;
  assign fmt.vco_on   = perp_1m ? RSK_VCO_1M : RSK_VCO_CONV;
  assign fmt.wg_pre   = perp_1m ? RSK_WG_PRE_1M :
                        perp_500k ? RSK_WG_PRE_500K : 6'h00;
  // write gate point measured back from sync start
  assign wg_point = fmt.gap2_len - fmt.wg_pre;

  rsk_gap_timer u_gap (
    .clk_in      (clk_in),
    .rst_b_in    (rst_b_in),
    .ce_in       (ce_in),
    .start_in    (gap2_start_in),
    .byte_stb_in (byte_stb_in),
    .count_out   (gap_cnt)
  );

  // vco lands two bytes past the gap2 end, a cushion into sync
  assign vco_on = in_gap_r && !write_op_in &&
                  gap_cnt >= fmt.gap2_len + RSK_CUSHION;
  assign wg_on  = in_gap_r && write_op_in && gap_cnt >= wg_point;
  assign idx_low = idx_cnt_r < fmt.idx_low;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      in_gap_r  <= 1'b0;
      idx_cnt_r <= 6'h3f;
    end else if (ce_in) begin
      if (gap2_start_in) begin
        in_gap_r <= 1'b1;
      end else if (!write_op_in && gap_cnt == 6'h3f) begin
        in_gap_r <= 1'b0;
      end
      if (idx_s && !idx_d_r) begin
        idx_cnt_r <= 6'h00;
      end else if (byte_stb_in && idx_cnt_r != 6'h3f) begin
        idx_cnt_r <= idx_cnt_r + 6'h01;
      end
    end
  end

  logic     vco_r;
  logic     wg_r;
  logic     idxl_r;
  rsk_fmt_t fmt_r;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      vco_r  <= 1'b0;
      wg_r   <= 1'b0;
      idxl_r <= 1'b0;
      fmt_r  <= '0;
    end else if (ce_in) begin
      vco_r  <= vco_on;
      wg_r   <= wg_on;
      idxl_r <= idx_low;
      fmt_r  <= fmt;
    end
  end

  assign step_out                    = step_r;
  assign dir_out                     = dir_r;
  assign busy_out                    = busy_r;
  assign int_out                     = int_r;
  assign status_byte_zero_out        = st0_r;
  assign present_cylinder_number_out = pcn_r;
  assign pll_oscillator_enable_out   = vco_r;
  assign write_gate_out              = wg_r;
  assign index_osc_low_out           = idxl_r;
  assign fmt_out                     = fmt_r;

  ////////////////////////////////////////////////////////////////////////
  property p_rel_dir;
    @(posedge clk_in) disable iff (!rst_b_in)
    ce_in && go_rseek |=> dir_out == $past(rel_dir);
  endproperty
  a_rel_dir: assert property (p_rel_dir) else $error("rel dir");

  property p_rel_count;
    @(posedge clk_in) disable iff (!rst_b_in)
    tick && state_r == RSK_RSEEK && ce_in && !seek_end |=>
      left_r == $past(left_r) - 9'h001;
  endproperty
  a_rel_count: assert property (p_rel_count) else $error("count");

  property p_ec;
    @(posedge clk_in) disable iff (!rst_b_in)
    ce_in && out_past_zero |=> status_byte_zero_out[RSK_ST0_EC_POS];
  endproperty
  a_ec: assert property (p_ec) else $error("ec not set");

  property p_wrap;
    @(posedge clk_in) disable iff (!rst_b_in)
    ce_in && tick && state_r == RSK_RSEEK && !seek_end && dir_r &&
      pcn_r == 8'hff |=> pcn_r == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");

  property p_recal_lim;
    @(posedge clk_in) disable iff (!rst_b_in)
    state_r == RSK_RECAL |-> recal_cnt_r <= RSK_RECAL_MAX_STEPS;
  endproperty
  a_recal_lim: assert property (p_recal_lim) else $error("recal");

  property p_reset_mode;
    @(posedge clk_in)
    !rst_b_in |=> mode_r == RSK_MODE_RESET;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode");

  property p_gap2;
    @(posedge clk_in) disable iff (!rst_b_in)
    ce_in && perp_1m |=> fmt_out.gap2_len == 6'h29;
  endproperty
  a_gap2: assert property (p_gap2) else $error("gap2");

  property p_int;
    @(posedge clk_in) disable iff (!rst_b_in)
    ce_in && seek_end |=> int_out && status_byte_zero_out[RSK_ST0_SE_POS];
  endproperty
  a_int: assert property (p_int) else $error("int");
endmodule
`default_nettype wire

// >>> dv/rsk_drive_model.sv
`timescale 1ns/1ns
`default_nettype none
// drive mechanism: head moves one track per rising step edge
module rsk_drive_model #(
  parameter int TRACKS = 300
) (
  input  wire logic clk_in,
  input  wire logic step_in,
  input  wire logic dir_in,
  output logic      track_zero_sense_out,
  output int        head_out
);
  logic step_d_r;
  initial head_out = 0;
  initial step_d_r = 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  // head stops at either end stop, as the real mechanism does
  always @(posedge clk_in) begin
    step_d_r <= step_in;
    if (step_in && !step_d_r) begin
      if (dir_in && head_out < TRACKS - 1)
        head_out <= head_out + 1;
      else if (!dir_in && head_out > 0)
        head_out <= head_out - 1;
    end
  end
  assign track_zero_sense_out = (head_out == 0);
endmodule
`default_nettype wire

// >>> dv/rsk_seek_gap_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module rsk_seek_gap_tb_top
  import rsk_pkg::*;
;
  logic       clk = 0, rst_b = 0, cmd_valid = 0, recal = 0, sense = 0;
  logic       mode_wr = 0, index = 0, byte_stb = 0, gap2_start = 0;
  logic       write_op = 0, ce = 1;
  logic [7:0] cmd_op = 8'h00, cmd_cyl = 8'h00, ep = 8'h00;
  logic [15:0] iv = 16'h0006;
  rsk_mode_t  mode = 2'h0;
  wire logic  step, dir, busy, intr, pll, wg, idxl, tz;
  wire logic [7:0] st0, present_cylinder_number;
  wire rsk_fmt_t fmt;
  rsk_fmt_t   fx;
  int         head, n_fail = 0, n_compared = 0, n_steps = 0, eh = 0, n;
  integer     seed = 32'h6812fce1;
  time        t_last;

  rsk_seek_gap i_rsk_seek_gap (.clk_in(clk), .rst_b_in(rst_b), .ce_in(ce),
    .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .cmd_cyl_in(cmd_cyl),
    .recal_in(recal), .sense_int_in(sense), .mode_wr_in(mode_wr),
    .mode_in(mode), .step_interval_setting_in(iv),
    .track_zero_sense_in(tz), .index_in(index), .byte_stb_in(byte_stb),
    .gap2_start_in(gap2_start), .write_op_in(write_op), .step_out(step),
    .dir_out(dir), .busy_out(busy), .int_out(intr),
    .status_byte_zero_out(st0), .present_cylinder_number_out(present_cylinder_number),
    .pll_oscillator_enable_out(pll), .write_gate_out(wg),
    .index_osc_low_out(idxl), .fmt_out(fmt));
  rsk_drive_model i_rsk_drive_model (.clk_in(clk), .step_in(step),
    .dir_in(dir), .track_zero_sense_out(tz), .head_out(head));

  initial forever #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      n_fail++;
    end
  endtask

  // the first gap may be short, so only later gaps are held to the interval
  always @(posedge step) begin
    if (n_steps > 0) chk(($time - t_last) >= iv * 100, 1);
    t_last = $time;
    n_steps++;
  end

  function automatic rsk_fmt_t fexp(input rsk_mode_t m);
    rsk_fmt_t r;
    logic f;
    f = m.gap & m.wgate;
    r.idx_low = f ? 6'h12 : 6'h21;
    r.gap2_len = f ? 6'h29 : 6'h16;
    r.vco_on = f ? 6'h2b : 6'h18;
    r.wg_pre = f ? 6'h26 : ((m == 2'h1) ? 6'h13 : 6'h00);
    return r;
  endfunction

  task automatic wait_int();
    for (int i = 0; i < 6000 && intr !== 1'b1; i++) @(negedge clk);
    if (intr !== 1'b1) begin
      n_fail++;
      complete_run();
    end
    // the drive model moves one edge after the last step pulse shows
    repeat (2) @(negedge clk);
    chk(busy, 0);
  endtask

  task automatic sense_clr();
    @(posedge clk) sense <= 1;
    @(posedge clk) sense <= 0;
    repeat (2) @(negedge clk);
    chk(intr, 0);
  endtask

  // a second command while busy must be dropped
  task automatic seek(input logic [7:0] op, input logic [7:0] c);
    n_steps = 0;
    @(posedge clk) cmd_valid <= 1;
    cmd_op <= op;
    cmd_cyl <= c;
    @(posedge clk) cmd_valid <= 0;
    @(posedge clk) cmd_valid <= 1;
    @(posedge clk) cmd_valid <= 0;
    // a short freeze early in the seek must lose and add no step
    ce <= 0;
    @(negedge clk) chk(busy, 1);
    repeat (4) @(posedge clk);
    ce <= 1;
    wait_int();
  endtask

  task automatic rel(input logic d, input logic [7:0] c);
    int k;
    k = (c == 8'h00) ? 256 : c;
    seek({1'b1, d, 6'h0f}, c);
    chk(n_steps, k);
    chk(dir, d);
    ep = d ? ep + k[7:0] : ep - k[7:0];
    chk(present_cylinder_number, ep);
    chk(st0[5], 1);
    chk(st0[4], !d && k > eh);
    eh = d ? eh + k : ((k > eh) ? 0 : eh - k);
    chk(head, eh);
    sense_clr();
  endtask

  task automatic abs_seek(input logic [7:0] t);
    seek({2'h0, 6'h0f}, t);
    chk(n_steps, (t > ep) ? t - ep : ep - t);
    chk(dir, t > ep);
    eh = (t > ep) ? eh + (t - ep) : eh - (ep - t);
    ep = t;
    chk(present_cylinder_number, t);
    chk(head, eh);
    sense_clr();
  endtask

  task automatic recal_chk();
    int x;
    x = (eh > 80) ? 80 : eh;
    n_steps = 0;
    @(posedge clk) recal <= 1;
    @(posedge clk) recal <= 0;
    wait_int();
    if (eh > 0) chk(n_steps, x);
    chk(st0[7:6], (eh > 80) ? 2'h1 : 2'h0);
    if (eh <= 80) begin
      chk(present_cylinder_number, 8'h00);
      ep = 8'h00;
    end
    eh = eh - x;
    sense_clr();
  endtask

  // counts byte strobes before the watched level goes high (index: low)
  task automatic meas(input int k, output int c);
    logic s;
    c = 0;
    @(posedge clk) write_op <= (k == 0);
    if (k == 2) index <= 1;
    else gap2_start <= 1;
    @(posedge clk) index <= 0;
    gap2_start <= 0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 80; i++) begin
      @(negedge clk);
      s = (k == 0) ? wg : ((k == 1) ? pll : !idxl);
      if (s === 1'b1) break;
      c++;
      @(posedge clk) byte_stb <= 1;
      @(posedge clk) byte_stb <= 0;
      repeat (2) @(posedge clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1;
    repeat (2) @(negedge clk);
    chk(fmt, fexp(2'h0));
    chk({st0, present_cylinder_number, intr}, 0);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk) mode <= m[1:0];
      mode_wr <= 1;
      @(posedge clk) mode_wr <= 0;
      repeat (2) @(negedge clk);
      fx = fexp(mode);
      chk(fmt, fx);
      meas(0, n);
      chk(n, fx.gap2_len - fx.wg_pre);
      meas(1, n);
      chk(n, fx.vco_on);
      meas(2, n);
      chk(n, fx.idx_low);
    end
    // reset in mid-run must drop the 1 Mbps mode left by the loop
    @(posedge clk) rst_b <= 0;
    @(posedge clk) rst_b <= 1;
    repeat (2) @(negedge clk);
    chk(fmt, fexp(2'h0));
    rel(0, 8'h03);
    recal_chk();
    repeat (3) rel(1, 8'h01 + 8'($unsigned($random(seed)) % 14));
    rel(1, 8'h00);
    abs_seek(ep + 8'h01);
    abs_seek(ep - 8'h02);
    for (int r = 0; r < 5 && eh > 0; r++) recal_chk();
    complete_run();
  end
endmodule
`default_nettype wire
